//--- tcsync_defs.vh
`ifndef TCSYNC_DEFS_VH
`define TCSYNC_DEFS_VH

// Channel count and widths
`define TCS_NCH 6
`define TCS_CNT_W 16
`define TCS_AW 8

// Register byte offsets
`define TCS_RUN_OFS 8'h00
`define TCS_LOCK_OFS 8'h04
`define TCS_CNT_BASE 8'h10
`define TCS_PIO_BASE 8'h30
`define TCS_CCR_BASE 8'h50
`define TCS_CMP_BASE 8'h70

// Reset values
`define TCS_RUN_RST 6'h00
`define TCS_LOCK_RST 6'h00
`define TCS_CNT_RST 16'h0000
`define TCS_PIO_RST 4'h0
`define TCS_CCR_RST 3'h0
`define TCS_CMP_RST 16'hFFFF

// Field positions of the run and lockstep registers
`define TCS_CH_MSB 5
`define TCS_RSV_MSB 7
`define TCS_RSV_LSB 6

// Pin I/O control fields
`define TCS_PIO_INIT 0
`define TCS_PIO_ACT_MSB 2
`define TCS_PIO_ACT_LSB 1
`define TCS_PIO_OE 3

// Compare output actions
`define TCS_ACT_NONE 2'h0
`define TCS_ACT_LOW 2'h1
`define TCS_ACT_HIGH 2'h2
`define TCS_ACT_TGL 2'h3

// Clear source field codes
`define TCS_CLR_NONE 3'h0
`define TCS_CLR_CMP 3'h1
`define TCS_CLR_SYNC 3'h3

`endif

//--- tcs_counter.v
`timescale 1ns/1ps
`include "tcsync_defs.vh"

module tcs_counter
(
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_run,
    input wire i_tick,
    input wire i_load,
    input wire [15:0] i_load_val,
    input wire i_sync_clear,
    input wire [15:0] i_cmp,
    input wire [2:0] i_clr_src,
    input wire [1:0] i_act,
    input wire i_pio_wr,
    input wire i_pio_init,
    output reg [15:0] o_count,
    output wire o_match,
    output reg o_pin
);

    wire cmp_clear;

    // Matches only happen on a counting tick, so a halted channel's pin changes only on a pin I/O write
    assign o_match = i_run && i_tick && (o_count == i_cmp);
    assign cmp_clear = o_match && (i_clr_src == `TCS_CLR_CMP);

    // Preset beats clear, clear beats counting
    always @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_count <= `TCS_CNT_RST;
        else if (i_load)
            o_count <= i_load_val;
        else if (i_sync_clear || cmp_clear)
            o_count <= `TCS_CNT_RST;
        else if (i_run && i_tick)
            o_count <= o_count + 16'h0001;
    end

    always @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_pin <= 1'h0;
        else if (i_pio_wr && !i_run)
            o_pin <= i_pio_init;
        else if (o_match)
        begin
            case (i_act)
                `TCS_ACT_LOW: o_pin <= 1'h0;
                `TCS_ACT_HIGH: o_pin <= 1'h1;
                `TCS_ACT_TGL: o_pin <= ~o_pin;
                default: o_pin <= o_pin;
            endcase
        end
    end

endmodule

//--- tcs_top.v
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "tcsync_defs.vh"

module tcs_top
(
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire [5:0] i_count_tick,
    output wire [5:0] o_channel_run_bit,
    output wire [5:0] o_lockstep,
    output wire [5:0] o_compare_match,
    output wire [5:0] o_timer_io_pin,
    output wire [5:0] o_timer_io_pin_oe
);

    // Returns {hit, index} for a six-word per-channel block at base
    function [3:0] chan_decode;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] diff;
        begin
            diff = addr - base;
            if ((addr >= base) && (diff[1:0] == 2'h0) && (diff[7:2] < 6'h6))
                chan_decode = {1'b1, diff[4:2]};
            else
                chan_decode = 4'h0;
        end
    endfunction

    reg [5:0] channel_run_control;
    reg [5:0] channel_lockstep_select;
    reg [3:0] pin_io_control [0:5];
    reg [2:0] channel_control_register [0:5];
    reg [15:0] compare_value [0:5];
    wire [15:0] channel_counter [0:5];
    wire [5:0] match;
    wire [5:0] pin;
    wire [5:0] load;
    wire [5:0] sync_clear;
    wire [5:0] pio_wr;

    wire [3:0] cnt_dec;
    wire [3:0] pio_dec;
    wire [3:0] ccr_dec;
    wire [3:0] cmp_dec;
    wire hit_run;
    wire hit_lock;
    wire hit_any;
    wire cnt_bad_strobe;
    wire access;
    wire setup;
    wire wr_ok;
    wire cnt_wr;
    wire sync_clear_event;
    wire [15:0] preset_val;
    wire [2:0] cnt_idx;

    assign cnt_dec = chan_decode(i_paddr, `TCS_CNT_BASE);
    assign pio_dec = chan_decode(i_paddr, `TCS_PIO_BASE);
    assign ccr_dec = chan_decode(i_paddr, `TCS_CCR_BASE);
    assign cmp_dec = chan_decode(i_paddr, `TCS_CMP_BASE);
    assign hit_run = (i_paddr == `TCS_RUN_OFS);
    assign hit_lock = (i_paddr == `TCS_LOCK_OFS);
    assign hit_any = hit_run || hit_lock || cnt_dec[3] || pio_dec[3] || ccr_dec[3] || cmp_dec[3];

    // Byte writes to a counter would tear the 16-bit value, so they are refused
    assign cnt_bad_strobe = cnt_dec[3] && i_pwrite && (i_pstrb[1:0] != 2'h3);

    // Zero-wait slave: the access phase always completes in one cycle
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign o_pready = access;
    assign o_pslverr = access && (!hit_any || cnt_bad_strobe);
    assign wr_ok = access && i_pwrite && hit_any && !cnt_bad_strobe;
    assign cnt_wr = wr_ok && cnt_dec[3];
    assign cnt_idx = cnt_dec[2:0];
    assign preset_val = i_pwdata[15:0];

    // Run and lockstep registers; reserved bits are not stored
    always @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            channel_run_control <= `TCS_RUN_RST;
            channel_lockstep_select <= `TCS_LOCK_RST;
        end
        else if (wr_ok)
        begin
            if (hit_run && i_pstrb[0])
                channel_run_control <= i_pwdata[`TCS_CH_MSB:0];
            if (hit_lock && i_pstrb[0])
                channel_lockstep_select <= i_pwdata[`TCS_CH_MSB:0];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `TCS_NCH; ch = ch + 1)
        begin : g_chan
            always @(posedge i_ref_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    pin_io_control[ch] <= `TCS_PIO_RST;
                    channel_control_register[ch] <= `TCS_CCR_RST;
                    compare_value[ch] <= `TCS_CMP_RST;
                end
                else
                begin
                    if (pio_wr[ch])
                        pin_io_control[ch] <= i_pwdata[3:0];
                    if (wr_ok && ccr_dec[3] && (ccr_dec[2:0] == ch) && i_pstrb[0])
                        channel_control_register[ch] <= i_pwdata[2:0];
                    if (wr_ok && cmp_dec[3] && (cmp_dec[2:0] == ch) && (i_pstrb[1:0] == 2'h3))
                        compare_value[ch] <= i_pwdata[15:0];
                end
            end

            assign pio_wr[ch] = wr_ok && pio_dec[3] && (pio_dec[2:0] == ch) && i_pstrb[0];

            // A write to any synchronised counter presets every synchronised counter
            assign load[ch] = cnt_wr && ((cnt_idx == ch) ||
                (channel_lockstep_select[cnt_idx] && channel_lockstep_select[ch]));

            // Only channels asking for sync clearing follow another channel's clear
            assign sync_clear[ch] = sync_clear_event && channel_lockstep_select[ch] &&
                (channel_control_register[ch] == `TCS_CLR_SYNC);

            tcs_counter u_counter
            (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_run(channel_run_control[ch]),
                .i_tick(i_count_tick[ch]),
                .i_load(load[ch]),
                .i_load_val(preset_val),
                .i_sync_clear(sync_clear[ch]),
                .i_cmp(compare_value[ch]),
                .i_clr_src(channel_control_register[ch]),
                .i_act(pin_io_control[ch][`TCS_PIO_ACT_MSB:`TCS_PIO_ACT_LSB]),
                .i_pio_wr(pio_wr[ch]),
                .i_pio_init(i_pwdata[`TCS_PIO_INIT]),
                .o_count(channel_counter[ch]),
                .o_match(match[ch]),
                .o_pin(pin[ch])
            );

            assign o_timer_io_pin_oe[ch] = pin_io_control[ch][`TCS_PIO_OE];
        end
    endgenerate

    // Clear source: a synchronised channel clearing on its own compare match
    function [5:0] cmp_clear_mask;
        input [5:0] m;
        input [5:0] sel;
        input [17:0] src;
        integer k;
        begin
            cmp_clear_mask = 6'h00;
            for (k = 0; k < 6; k = k + 1)
                cmp_clear_mask[k] = m[k] && sel[k] && (src[3*k +: 3] == `TCS_CLR_CMP);
        end
    endfunction

    // A lone lockstep bit has no partner, so its clear reaches nothing else
    assign sync_clear_event = |cmp_clear_mask(match, channel_lockstep_select,
        {channel_control_register[5], channel_control_register[4], channel_control_register[3],
         channel_control_register[2], channel_control_register[1], channel_control_register[0]});

    // Read data captured in the setup phase so the output comes from a flop
    always @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_prdata <= 32'h00000000;
        else if (setup && !i_pwrite)
        begin
            if (hit_run)
                o_prdata <= {26'h0, channel_run_control};
            else if (hit_lock)
                o_prdata <= {26'h0, channel_lockstep_select};
            else if (cnt_dec[3])
                o_prdata <= {16'h0000, channel_counter[cnt_dec[2:0]]};
            else if (pio_dec[3])
                o_prdata <= {28'h0000000, pin_io_control[pio_dec[2:0]]};
            else if (ccr_dec[3])
                o_prdata <= {29'h0, channel_control_register[ccr_dec[2:0]]};
            else if (cmp_dec[3])
                o_prdata <= {16'h0000, compare_value[cmp_dec[2:0]]};
            else
                o_prdata <= 32'h00000000;
        end
    end

    assign o_channel_run_bit = channel_run_control;
    assign o_lockstep = channel_lockstep_select;
    assign o_compare_match = match;
    assign o_timer_io_pin = pin;

endmodule

//--- tcs_top_properties.sv
`timescale 1ns/1ps
module tcs_chk
(
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    input wire [31:0] o_prdata,
    input wire [5:0] o_channel_run_bit,
    input wire [5:0] o_lockstep,
    input wire [5:0] o_compare_match,
    input wire [5:0] o_timer_io_pin
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire acc = i_psel && i_penable;
    sequence s_wr(logic [7:0] a);
        acc && i_pwrite && i_paddr == a && i_pstrb[0];
    endsequence
    sequence s_rd(logic [7:0] a);
        acc && !i_pwrite && i_paddr == a;
    endsequence
    a_run_write: assert property (s_wr(8'h00) |=> o_channel_run_bit == $past(i_pwdata[5:0]))
        else $error("run bits not written");
    a_lock_write: assert property (s_wr(8'h04) |=> o_lockstep == $past(i_pwdata[5:0]))
        else $error("lockstep bits not written");
    a_run_rsv_read: assert property (s_rd(8'h00) |-> o_prdata[31:6] == 26'h0)
        else $error("run reserved bits read 1");
    a_lock_rsv_read: assert property (s_rd(8'h04) |-> o_prdata[31:6] == 26'h0)
        else $error("lockstep reserved bits read 1");
    a_halt_no_match: assert property ((o_compare_match & ~o_channel_run_bit) == 6'h00)
        else $error("match on halted channel");
    a_halt_pin_hold: assert property (!o_channel_run_bit[0] && !(acc && i_paddr == 8'h30) |=>
        o_timer_io_pin[0] == $past(o_timer_io_pin[0])) else $error("halted pin moved");
    a_pio_init: assert property (!o_channel_run_bit[0] ##0 s_wr(8'h30) |=>
        o_timer_io_pin[0] == $past(i_pwdata[0])) else $error("pin not at initial level");
    a_reset_idle: assert property ($rose(i_rst_b) |-> o_channel_run_bit == 6'h00 && o_lockstep == 6'h00)
        else $error("registers not zero after reset");
endmodule
bind tcs_top tcs_chk i_chk (.i_ref_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb, .o_prdata, .o_channel_run_bit, .o_lockstep, .o_compare_match, .o_timer_io_pin);

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
    reg clk, rst_b, psel, pen, pwr, er;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd, v;
    reg [3:0] pstrb;
    reg [5:0] tick;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [5:0] run, lock, match, pin, oe;
    integer miscompares = 0;
    integer check_count = 0;
    integer match_seen = 0;
    // The compare pulse stands for one cycle only, so it is counted at every edge
    always @(posedge clk)
    begin
        if (match[0])
            match_seen <= match_seen + 1;
    end
    tcs_top i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_count_tick(tick), .o_channel_run_bit(run), .o_lockstep(lock),
        .o_compare_match(match), .o_timer_io_pin(pin), .o_timer_io_pin_oe(oe));
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task close_out;
        begin
            if (miscompares == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Zero-wait slave, but the wait stays bounded in case pready never comes
    task automatic apb(input [7:0] a, input [31:0] d, input w, input [3:0] s);
        integer n;
        begin
            psel <= 1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            pstrb <= s;
            @(posedge clk);
            pen <= 1;
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end while (!pready && n < 50);
            if (!pready)
            begin
                miscompares++;
                close_out;
            end
            rd = prdata;
            er = pslverr;
            psel <= 0;
            pen <= 0;
            @(posedge clk);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        apb(a, d, 1, 4'hF);
    endtask
    task automatic rdc(input [7:0] a, input [31:0] e);
        begin
            apb(a, 32'h0, 0, 4'hF);
            `CHK($sformatf("addr %h", a), e, rd)
        end
    endtask
    initial
    begin
        rst_b <= 0;
        {psel, pen, pwr, paddr, pwdata, pstrb} <= 0;
        tick <= 6'h3F;
        repeat (10) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h10, 32'h0);
        wr(8'h00, 32'h3F);
        `CHK("run", 6'h3F, run)
        rdc(8'h00, 32'h3F);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h3F);
        rdc(8'h04, 32'h3F);
        apb(8'h10, 32'h0, 0, 4'hF);
        v = rd;
        repeat (3) @(posedge clk);
        rdc(8'h10, v);
        apb(8'h10, 32'h5555, 1, 4'h1);
        `CHK("byte write error", 1'h1, er)
        rdc(8'h10, v);
        wr(8'h04, 32'h07);
        `CHK("lockstep", 6'h07, lock)
        wr(8'h10, 32'hBEEF);
        rdc(8'h14, 32'hBEEF);
        rdc(8'h18, 32'hBEEF);
        wr(8'h50, 32'h1);
        wr(8'h54, 32'h3);
        wr(8'h70, 32'h5);
        wr(8'h30, 32'hF);
        `CHK("pin0 init", 2'h3, {oe[0], pin[0]})
        wr(8'h10, 32'h0);
        // 43 counting edges with a period of six: seven matches, count ends at one
        wr(8'h00, 32'h03);
        repeat (40) @(posedge clk);
        wr(8'h00, 32'h0);
        `CHK("ch0 matches", 7, match_seen)
        apb(8'h10, 32'h0, 0, 4'hF);
        `CHK("ch0 wraps at compare", 32'h1, rd)
        rdc(8'h14, 32'h1);
        repeat (10) @(posedge clk);
        `CHK("halted pin", 1'h0, pin[0])
        wr(8'h3C, 32'h9);
        `CHK("pin3 high", 2'h3, {oe[3], pin[3]})
        wr(8'h3C, 32'h8);
        `CHK("pin3 low", 1'h0, pin[3])
        apb(8'h08, 32'h0, 0, 4'hF);
        `CHK("unmapped", 33'h100000000, {er, rd})
        wr(8'h00, 32'h3F);
        wr(8'h04, 32'h3F);
        // Without count ticks a running channel holds its value
        tick <= 6'h00;
        apb(8'h14, 32'h0, 0, 4'hF);
        v = rd;
        repeat (3) @(posedge clk);
        rdc(8'h14, v);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        `CHK("run after reset", 6'h00, run)
        `CHK("lockstep after reset", 6'h00, lock)
        rdc(8'h14, 32'h0);
        close_out;
    end
endmodule
